// >>> fesc_params.svh
// Purpose: constants of the flash erase-suspend control block
// Assumes: 10 MHz clock; registers are 8 bits wide in the low byte
// Notes: register indices times four give the byte address
`ifndef FESC_PARAMS_SVH
`define FESC_PARAMS_SVH

// ==========================================================================
// register indices and reset values
`define FESC_IDX_SUSPEND_CTRL 10'h1B6
`define FESC_IDX_CONTROL_ZERO 10'h1B4
`define FESC_IDX_STATUS 10'h1B0
`define FESC_IDX_COMMAND 10'h1B1
`define FESC_SCR_RESET 8'h00
`define FESC_CZR_RESET 8'h00

// ==========================================================================
// field positions
`define FESC_B_SUS_EN 0
`define FESC_B_SUS_REQ 1
`define FESC_B_IRQ_SUS_EN 2
`define FESC_B_LCR_EN 7
`define FESC_B_RW_EN 1
`define FESC_B_MODE_SEL 2
`define FESC_B_FSTOP 3
`define FESC_B_SEQ_RST 4
`define FESC_B_LCR_ACT 0
`define FESC_B_SUS_FLAG 6
`define FESC_B_READY 7
`define FESC_B_CMD_ERASE 0
`define FESC_B_CMD_PROG 1
`define FESC_B_CMD_AREA 2
`define FESC_B_CMD_BLK 4

// ==========================================================================
// timing
`define FESC_CLK_KHZ 10000
`define FESC_ERASE_TIME_US 200
`define FESC_PROG_TIME_US 50
`define FESC_SUS_DELAY_US 5
`define FESC_ERASE_CYC ((`FESC_ERASE_TIME_US * `FESC_CLK_KHZ) / 1000)
`define FESC_PROG_CYC ((`FESC_PROG_TIME_US * `FESC_CLK_KHZ) / 1000)
`define FESC_SUS_DLY_CYC ((`FESC_SUS_DELAY_US * `FESC_CLK_KHZ) / 1000)

`endif

// >>> fesc_pkg.sv
// Purpose: types of the flash erase-suspend control block
// Assumes: nothing
// Notes: shared by the top and the erase engine
`default_nettype none

package fesc_pkg;
  // ========================================================================
  // access check
  typedef enum logic [2:0] {
    FESC_OP_READ,
    FESC_OP_PROGRAM,
    FESC_OP_ERASE,
    FESC_OP_BLANK,
    FESC_OP_LOCK_PROG,
    FESC_OP_LOCK_READ,
    FESC_OP_CLR_STATUS
  } fesc_op_t;

  typedef struct packed {
    logic rom_area;
    logic [1:0] block;
  } fesc_target_t;

  typedef struct packed {
    fesc_op_t op;
    fesc_target_t where;
  } fesc_access_t;

  // ========================================================================
  // erase engine
  typedef enum logic [2:0] {
    FESC_ENG_IDLE,
    FESC_ENG_ERASE,
    FESC_ENG_SUS_WAIT,
    FESC_ENG_SUSPENDED,
    FESC_ENG_PROG
  } fesc_eng_state_t;

  typedef struct packed {
    logic ready;
    logic suspended;
    logic erasing;
    logic programming;
  } fesc_eng_stat_t;
endpackage : fesc_pkg

`default_nettype wire

// >>> fesc_erase_engine.sv
// Purpose: auto-erase and auto-program sequencer with erase-suspend
// Assumes: suspend_go already qualified by the suspend enable
// Notes: the remaining erase time is kept across a suspend
`timescale 1ns/1ps
`default_nettype none
`include "fesc_params.svh"

module fesc_erase_engine import fesc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // commands
  input wire logic start_erase,
  input wire logic start_prog,
  input wire logic suspend_go,
  input wire logic abort,
  // state
  output var fesc_eng_stat_t stat
);
  localparam logic [11:0] ERASE_CYC = 12'(`FESC_ERASE_CYC);
  localparam logic [11:0] PROG_CYC = 12'(`FESC_PROG_CYC);
  localparam logic [11:0] SUS_CYC = 12'(`FESC_SUS_DLY_CYC);
  localparam int SDLY1 = `FESC_SUS_DLY_CYC + 1;

  fesc_eng_state_t state_q, state_d;
  logic [11:0] left_q, left_d, dly_q, dly_d;
  logic back_q, back_d;

  // ==========================================================================
  // sequencer
  always_comb begin
    state_d = state_q;
    left_d = left_q;
    dly_d = dly_q;
    back_d = back_q;
    unique case (state_q)
      FESC_ENG_IDLE: begin
        if (start_erase) begin
          state_d = FESC_ENG_ERASE;
          left_d = ERASE_CYC;
        end else if (start_prog) begin
          state_d = FESC_ENG_PROG;
          dly_d = PROG_CYC;
          back_d = 1'b0;
        end
      end
      FESC_ENG_ERASE: begin
        if (left_q == 12'h001) begin
          state_d = FESC_ENG_IDLE;
        end else begin
          left_d = left_q - 12'h001;
          if (suspend_go) begin
            state_d = FESC_ENG_SUS_WAIT;
            dly_d = SUS_CYC;
          end
        end
      end
      FESC_ENG_SUS_WAIT: begin
        // erase keeps running until the suspend delay is over
        if (left_q == 12'h001) begin
          state_d = FESC_ENG_IDLE;
        end else begin
          left_d = left_q - 12'h001;
          if (!suspend_go) begin
            state_d = FESC_ENG_ERASE;
          end else if (dly_q == 12'h001) begin
            state_d = FESC_ENG_SUSPENDED;
          end else begin
            dly_d = dly_q - 12'h001;
          end
        end
      end
      FESC_ENG_SUSPENDED: begin
        if (!suspend_go) begin
          state_d = FESC_ENG_ERASE;
        end else if (start_prog) begin
          state_d = FESC_ENG_PROG;
          dly_d = PROG_CYC;
          back_d = 1'b1;
        end
      end
      FESC_ENG_PROG: begin
        // programming ignores suspend requests
        if (dly_q == 12'h001) begin
          state_d = back_q ? FESC_ENG_SUSPENDED : FESC_ENG_IDLE;
        end else begin
          dly_d = dly_q - 12'h001;
        end
      end
    endcase
    if (abort) begin
      state_d = FESC_ENG_IDLE;
      back_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= FESC_ENG_IDLE;
      left_q <= 12'h000;
      dly_q <= 12'h000;
      back_q <= 1'b0;
    end else begin
      state_q <= state_d;
      left_q <= left_d;
      dly_q <= dly_d;
      back_q <= back_d;
    end
  end

  assign stat = '{
    ready: (state_q == FESC_ENG_IDLE) || (state_q == FESC_ENG_SUSPENDED),
    suspended: state_q == FESC_ENG_SUSPENDED,
    erasing: (state_q == FESC_ENG_ERASE) || (state_q == FESC_ENG_SUS_WAIT),
    programming: state_q == FESC_ENG_PROG
  };

  // ==========================================================================
  // checks
  chk_no_prog_susp: assert property (
    @(posedge clk) disable iff (reset)
    state_q == FESC_ENG_PROG |=> state_q != FESC_ENG_SUS_WAIT)
    else $error("programming entered a suspend wait");

  chk_sus_delay: assert property (
    @(posedge clk) disable iff (reset)
    (state_q == FESC_ENG_ERASE && suspend_go && !abort &&
     left_q > 12'(SDLY1 + 2))
    |-> ##[1:SDLY1] (state_q == FESC_ENG_SUSPENDED || !suspend_go || abort))
    else $error("erase did not halt within the suspend delay");
endmodule : fesc_erase_engine

`default_nettype wire

// >>> fesc_top.sv
// Purpose: flash rewrite mode and erase-suspend control, Wishbone slave
// Assumes: irq_req, lso_mode and xin_stopped come from logic on clk
// Notes: registers sit in the low byte of each 32-bit word
`timescale 1ns/1ps
`default_nettype none
`include "fesc_params.svh"

module fesc_top import fesc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // system state
  input wire logic irq_req,
  input wire logic lso_mode,
  input wire logic xin_stopped,
  // flash access check
  input wire fesc_access_t acc_i,
  output logic acc_ok,
  // flash array side
  output logic rewrite_mode_a,
  output logic rewrite_mode_b,
  output logic array_read_mode,
  output logic low_current_read,
  output logic flash_stop,
  output fesc_target_t erase_target,
  output logic erase_active,
  output logic suspended
);
  // ==========================================================================
  // bus decode
  function automatic logic hit(input logic [11:0] adr,
                               input logic [9:0] idx);
    return adr[11:2] == idx;
  endfunction : hit

  logic ack_q;
  logic [31:0] dat_q;
  wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire logic wr = bus_req & wb_we_i & wb_sel_i[0];
  wire logic [7:0] wd = wb_dat_i[7:0];
  wire logic hit_scr = hit(wb_adr_i, `FESC_IDX_SUSPEND_CTRL);
  wire logic hit_czr = hit(wb_adr_i, `FESC_IDX_CONTROL_ZERO);
  wire logic hit_st = hit(wb_adr_i, `FESC_IDX_STATUS);
  wire logic hit_cmd = hit(wb_adr_i, `FESC_IDX_COMMAND);
  wire logic wr_scr = wr & hit_scr;
  wire logic wr_czr = wr & hit_czr;
  wire logic wr_cmd = wr & hit_cmd;

  // ==========================================================================
  // register state
  localparam logic [7:0] SCR_RST = `FESC_SCR_RESET;
  localparam logic [7:0] CZR_RST = `FESC_CZR_RESET;

  logic sus_en_q, sus_req_q, sus_req_d, irq_sus_en_q, lcr_en_q;
  logic [2:0] rsv_q;
  logic rw_en_q, mode_sel_q, fstop_q, lcr_act_q;
  fesc_target_t target_q;
  fesc_eng_stat_t eng;

  wire logic seq_rst = wr_czr & wd[`FESC_B_SEQ_RST];
  wire logic suspend_go = sus_req_q & sus_en_q;
  // interrupt only counts while an erase is running
  wire logic irq_set = irq_req & irq_sus_en_q & sus_en_q & rw_en_q
                     & eng.erasing & ~seq_rst;
  wire logic sw_req_ok = wd[`FESC_B_SUS_REQ] | rw_en_q;

  // ==========================================================================
  // commands
  wire logic cmd_ok = rw_en_q & ~lcr_en_q & ~fstop_q;
  wire logic want_erase = wr_cmd & wd[`FESC_B_CMD_ERASE];
  wire logic want_prog = wr_cmd & wd[`FESC_B_CMD_PROG] & ~want_erase;
  wire fesc_target_t cmd_where = '{
    rom_area: wd[`FESC_B_CMD_AREA],
    block: wd[`FESC_B_CMD_BLK +: 2]
  };
  wire logic other_blk = cmd_where != target_q;
  // no new erase while one is suspended
  wire logic erase_go = want_erase & cmd_ok & eng.ready
                      & ~eng.suspended;
  wire logic prog_go = want_prog & cmd_ok & eng.ready
                     & (~eng.suspended | other_blk);

  always_comb begin
    sus_req_d = sus_req_q;
    if (wr_scr && sw_req_ok) begin
      sus_req_d = wd[`FESC_B_SUS_REQ];
    end
    if (seq_rst) begin
      sus_req_d = 1'b0;
    end
    if (irq_set) begin
      sus_req_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sus_en_q <= SCR_RST[`FESC_B_SUS_EN];
      irq_sus_en_q <= SCR_RST[`FESC_B_IRQ_SUS_EN];
      lcr_en_q <= SCR_RST[`FESC_B_LCR_EN];
      rsv_q <= SCR_RST[6:4];
    end else if (wr_scr) begin
      sus_en_q <= wd[`FESC_B_SUS_EN];
      irq_sus_en_q <= wd[`FESC_B_IRQ_SUS_EN];
      lcr_en_q <= wd[`FESC_B_LCR_EN];
      rsv_q <= wd[6:4];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sus_req_q <= SCR_RST[`FESC_B_SUS_REQ];
    end else begin
      sus_req_q <= sus_req_d;
    end
  end

  // mode select only sets once rewrite is already enabled
  always_ff @(posedge clk) begin
    if (reset) begin
      rw_en_q <= CZR_RST[`FESC_B_RW_EN];
      mode_sel_q <= CZR_RST[`FESC_B_MODE_SEL];
      fstop_q <= CZR_RST[`FESC_B_FSTOP];
    end else if (wr_czr) begin
      rw_en_q <= wd[`FESC_B_RW_EN];
      mode_sel_q <= wd[`FESC_B_MODE_SEL] & rw_en_q
                  & wd[`FESC_B_RW_EN];
      fstop_q <= wd[`FESC_B_FSTOP];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      target_q <= '0;
      lcr_act_q <= 1'b0;
    end else begin
      if (erase_go) begin
        target_q <= cmd_where;
      end
      lcr_act_q <= lcr_en_q & lso_mode & xin_stopped;
    end
  end

  // ==========================================================================
  // erase engine
  fesc_erase_engine u_engine (
    .clk(clk),
    .reset(reset),
    .start_erase(erase_go),
    .start_prog(prog_go),
    .suspend_go(suspend_go),
    .abort(seq_rst),
    .stat(eng)
  );

  // ==========================================================================
  // access gating
  wire logic same_blk = acc_i.where == target_q;
  wire logic op_rd = acc_i.op == FESC_OP_READ;
  wire logic op_clr = acc_i.op == FESC_OP_CLR_STATUS;
  wire logic op_susp_ok = op_rd | (acc_i.op == FESC_OP_PROGRAM)
                        | (acc_i.op == FESC_OP_LOCK_PROG)
                        | (acc_i.op == FESC_OP_LOCK_READ);
  // erase and blank check never pass during suspend
  wire logic ok_susp = (op_clr & eng.ready)
                     | (~same_blk & op_susp_ok
                        & (op_rd | rw_en_q));
  // background read of rom while data flash erases
  wire logic ok_busy = op_rd & eng.erasing & ~target_q.rom_area
                     & acc_i.where.rom_area;
  wire logic ok_idle = op_rd | rw_en_q;
  assign acc_ok = eng.suspended ? ok_susp
                : (eng.ready ? ok_idle : ok_busy);

  // ==========================================================================
  // outputs
  assign rewrite_mode_a = rw_en_q & ~mode_sel_q;
  assign rewrite_mode_b = rw_en_q & mode_sel_q;
  assign array_read_mode = eng.ready;
  assign low_current_read = lcr_act_q;
  assign flash_stop = fstop_q;
  assign erase_target = target_q;
  assign erase_active = eng.erasing;
  assign suspended = eng.suspended;

  // ==========================================================================
  // register read
  wire logic [7:0] scr_rd = {lcr_en_q, rsv_q, 1'b0, irq_sus_en_q,
                             sus_req_q, sus_en_q};
  wire logic [7:0] czr_rd = {4'h0, fstop_q, mode_sel_q, rw_en_q, 1'b0};
  wire logic [7:0] st_rd = {eng.ready, eng.suspended, 5'h00,
                            lcr_act_q};
  wire logic [7:0] rd_byte = hit_scr ? scr_rd
                           : hit_czr ? czr_rd
                           : hit_st ? st_rd : 8'h00;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= bus_req;
      if (bus_req && !wb_we_i) begin
        dat_q <= {24'h000000, rd_byte};
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_sus_needs_en: assert property (
    (!sus_en_q && !eng.suspended) |=> !eng.suspended)
    else $error("suspend entered with suspend disabled");

  chk_restart_flags: assert property (
    (eng.suspended && !sus_req_q && !seq_rst)
    |=> (!eng.ready && !eng.suspended && eng.erasing))
    else $error("erase did not restart on cleared request");

  chk_irq_sets_req: assert property (
    irq_set |=> sus_req_q)
    else $error("interrupt did not raise the suspend request");

  chk_low_current: assert property (
    (lcr_en_q && lso_mode && xin_stopped) ##1 (lcr_en_q && lso_mode)
    |-> low_current_read)
    else $error("low-current read mode not entered");

  chk_mode_select: assert property (
    $rose(mode_sel_q) |-> $past(rw_en_q) && rewrite_mode_b)
    else $error("mode b selected without prior rewrite enable");

  chk_erase_busy: assert property (
    erase_go |=> (!eng.ready && eng.erasing) [*2])
    else $error("ready flag not low during erase");

  chk_blank_refused: assert property (
    (eng.suspended && acc_i.op == FESC_OP_BLANK) |-> !acc_ok)
    else $error("blank check allowed during suspend");

  chk_same_block: assert property (
    (eng.suspended && same_blk && !op_clr) |-> !acc_ok)
    else $error("suspended block was accessible");

  chk_other_read: assert property (
    (eng.suspended && !same_blk && op_rd) |-> acc_ok)
    else $error("read of another block refused during suspend");

  chk_seq_reset: assert property (
    seq_rst |=> (!eng.suspended && !sus_req_q && eng.ready))
    else $error("sequence reset left suspend state");

  chk_array_read: assert property (
    $rose(eng.suspended) |-> (array_read_mode && eng.ready))
    else $error("no array read mode on suspend entry");

  chk_bit3_zero: assert property (
    (bus_req && !wb_we_i && hit_scr) |=> (wb_ack_o && !wb_dat_o[3]))
    else $error("suspend control bit 3 read non-zero");
endmodule : fesc_top

`default_nettype wire

// >>> fesc_flash_model.sv
// Purpose: flash array side, presents access requests to the block
// Assumes: requests change only right after a rising edge
// Notes: idle request is a read of data flash block 0
`timescale 1ns/1ps
`default_nettype none

module fesc_flash_model import fesc_pkg::*; (
  // clock
  input wire logic clk,
  // access request toward the block
  output var fesc_access_t acc
);
  initial acc = {FESC_OP_READ, 3'h0};

  // ========================================================================
  // present one access, then hold it until the next request
  task automatic ask(input fesc_op_t op, input logic [2:0] w);
    @(posedge clk);
    acc <= {op, w};
  endtask : ask
endmodule : fesc_flash_model

`default_nettype wire

// >>> tb_top.sv
// Purpose: self-checking bench of the erase-suspend control block
// Assumes: one ack per request, erase 2000 and program 500 cycles
// Notes: expected register values come from the bit map alone
`timescale 1ns/1ps
`default_nettype none

module tb_top import fesc_pkg::*;;
  localparam logic [11:0] A_SCR = 12'h6D8;
  localparam logic [11:0] A_CZR = 12'h6D0;
  localparam logic [11:0] A_ST = 12'h6C0;
  localparam logic [11:0] A_CMD = 12'h6C4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dout;
  logic ack;
  logic irq = 1'b0;
  logic lso = 1'b0;
  logic xin = 1'b0;
  fesc_access_t acc;
  logic acc_ok, mode_a, mode_b, arm, lcr, fstop, eact, susp;
  fesc_target_t etgt;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  fesc_flash_model fm (.clk(clk), .acc(acc));

  fesc_top dut_u (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack), .irq_req(irq),
    .lso_mode(lso), .xin_stopped(xin), .acc_i(acc), .acc_ok(acc_ok),
    .rewrite_mode_a(mode_a), .rewrite_mode_b(mode_b),
    .array_read_mode(arm), .low_current_read(lcr), .flash_stop(fstop),
    .erase_target(etgt), .erase_active(eact), .suspended(susp));

  // ========================================================================
  // common tasks
  task automatic finish_test();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // classic cycle: hold until ack is sampled high
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, {24'h0, e});
  endtask : rd_chk

  // poll suspended (s=1) or array ready (s=0) for a bounded time
  task automatic wait_on(input bit s, input logic v, input int lim);
    int n;
    n = 0;
    while ((s ? susp : arm) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    check(s ? susp : arm, v);
  endtask : wait_on

  task automatic acc_chk(input fesc_op_t op, input logic [2:0] w,
                         input logic e);
    fm.ask(op, w);
    @(negedge clk);
    check(acc_ok, e);
  endtask : acc_chk

  // ========================================================================
  // scenarios
  task automatic t_reset();
    rd_chk(A_SCR, 8'h00);
    rd_chk(A_CZR, 8'h00);
    rd_chk(A_ST, 8'h80);
    rd_chk(12'h004, 8'h00);
    acc_chk(FESC_OP_READ, 3'h0, 1'b1);
    acc_chk(FESC_OP_PROGRAM, 3'h0, 1'b0);
  endtask : t_reset

  task automatic t_modes();
    wr(A_CZR, 8'h06);
    check({mode_a, mode_b}, 2'b10);
    wr(A_CZR, 8'h06);
    check({mode_a, mode_b}, 2'b01);
    wr(A_CZR, 8'h02);
    check({mode_a, mode_b, fstop}, 3'b100);
  endtask : t_modes

  task automatic t_regs();
    lso <= 1'b1;
    xin <= 1'b1;
    wr(A_SCR, 8'h00);
    wr(A_SCR, 8'hFF);
    rd_chk(A_SCR, 8'hF7);
    check(lcr, 1'b1);
    rd_chk(A_ST, 8'h81);
    lso <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check(lcr, 1'b0);
    wr(A_SCR, 8'h00);
    rd_chk(A_SCR, 8'h00);
  endtask : t_regs

  task automatic t_sw_suspend();
    fesc_op_t ops[9] = '{FESC_OP_READ, FESC_OP_READ, FESC_OP_PROGRAM,
      FESC_OP_ERASE, FESC_OP_BLANK, FESC_OP_READ, FESC_OP_CLR_STATUS,
      FESC_OP_LOCK_PROG, FESC_OP_LOCK_READ};
    logic [2:0] ws[9] = '{0, 1, 1, 1, 1, 4, 0, 1, 1};
    logic es[9] = '{0, 1, 1, 0, 0, 1, 1, 1, 1};
    wr(A_SCR, 8'h00);
    wr(A_SCR, 8'h01);
    wr(A_CMD, 8'h01);
    rd_chk(A_ST, 8'h00);
    check(eact, 1'b1);
    wr(A_SCR, 8'h03);
    wait_on(1'b1, 1'b1, 100);
    rd_chk(A_ST, 8'hC0);
    check(arm, 1'b1);
    for (int i = 0; i < 9; i++) begin
      acc_chk(ops[i], ws[i], es[i]);
    end
    wr(A_SCR, 8'h01);
    rd_chk(A_ST, 8'h00);
    check(susp, 1'b0);
    wait_on(1'b0, 1'b1, 2100);
    rd_chk(A_ST, 8'h80);
  endtask : t_sw_suspend

  task automatic t_no_enable();
    wr(A_SCR, 8'h00);
    wr(A_CMD, 8'h11);
    wr(A_SCR, 8'h02);
    // longer than the suspend delay: a working suspend would show by now
    repeat (100) @(posedge clk);
    check(susp, 1'b0);
    check({susp, eact}, 2'b01);
    wait_on(1'b0, 1'b1, 2100);
    wr(A_SCR, 8'h00);
  endtask : t_no_enable

  task automatic t_irq();
    wr(A_CZR, 8'h06);
    wr(A_SCR, 8'h00);
    wr(A_SCR, 8'h05);
    wr(A_CMD, 8'h15);
    @(posedge clk);
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
    rd_chk(A_SCR, 8'h07);
    wait_on(1'b1, 1'b1, 100);
    check(etgt, 3'b101);
    acc_chk(FESC_OP_READ, 3'h5, 1'b0);
    acc_chk(FESC_OP_READ, 3'h1, 1'b1);
    acc_chk(FESC_OP_PROGRAM, 3'h4, 1'b1);
    acc_chk(FESC_OP_ERASE, 3'h0, 1'b0);
    wr(A_CZR, 8'h16);
    @(negedge clk);
    check(susp, 1'b0);
    rd_chk(A_SCR, 8'h05);
    rd_chk(A_ST, 8'h80);
  endtask : t_irq

  task automatic t_prog();
    wr(A_CZR, 8'h02);
    wr(A_CMD, 8'h02);
    wr(A_SCR, 8'h07);
    repeat (100) @(posedge clk);
    check(susp, 1'b0);
    wait_on(1'b0, 1'b1, 600);
    rd_chk(A_ST, 8'h80);
    wr(A_SCR, 8'h05);
  endtask : t_prog

  // ========================================================================
  // main sequence and hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_modes();
    t_regs();
    t_sw_suspend();
    t_no_enable();
    t_irq();
    t_prog();
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
